// file: core/ee_regs.svh
// constants for the sixteen-word serial memory port and its host
// assumes a system clock of 5 ns and a serial clock made by the host
`ifndef EE_REGS_SVH
`define EE_REGS_SVH

// geometry
`define EE_WORDS 16
`define EE_WIDTH 16
`define EE_ADDR_W 4
`define EE_OP_W 4
`define EE_CNT_W 5

// instruction fields
`define EE_START_BIT 1'h1
`define EE_KIND_SPECIAL 2'h0
`define EE_KIND_WRITE 2'h1
`define EE_KIND_READ 2'h2
`define EE_KIND_ERASE 2'h3
`define EE_OP_DISABLE 4'h0
`define EE_OP_WRITE_ALL 4'h1
`define EE_OP_ERASE_ALL 4'h2
`define EE_OP_ENABLE 4'h3
`define EE_ERASED 16'hffff

// last serial clock slot of each frame, counted from the lead slot as slot 0
`define EE_SLOT_CMD_LAST 5'h09
`define EE_SLOT_DATA_LAST 5'h19

// timing
`define EE_CLK_PERIOD_NS 5
`define EE_LINK_NS 5000
`define EE_CS_LOW_NS 1000
`define EE_PROG_TIME_MS 10
`define EE_LINK_HALF ((`EE_LINK_NS + 2 * `EE_CLK_PERIOD_NS - 1) / (2 * `EE_CLK_PERIOD_NS))
`define EE_CS_LOW_CYC ((`EE_CS_LOW_NS + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)
`define EE_PROG_CYC ((`EE_PROG_TIME_MS * 1000000 + `EE_CLK_PERIOD_NS - 1) / `EE_CLK_PERIOD_NS)

`endif

// file: core/ee_pkg.sv
// types shared by both ends of the serial memory link
// assumes ee_regs.svh is on the include path
`default_nettype none
`include "ee_regs.svh"

package ee_pkg;
  typedef logic [`EE_OP_W-1:0] ee_op_t;
  typedef logic [`EE_ADDR_W-1:0] ee_addr_t;
  typedef logic [`EE_WIDTH-1:0] ee_word_t;
  typedef enum logic [2:0] {EE_DEV_IDLE, EE_DEV_CMD, EE_DEV_DATA, EE_DEV_READ, EE_DEV_DONE}
    ee_dev_state_t;
  typedef enum logic [2:0] {EE_HOST_IDLE, EE_HOST_FRAME, EE_HOST_FLUSH, EE_HOST_WAIT,
    EE_HOST_ENDHI} ee_host_state_t;
endpackage : ee_pkg

`default_nettype wire

// file: core/ee_link_if.sv
// three-wire serial link plus the returned data line
// the data line is resolved here from the device's output enable
`timescale 1ns/1ps
`default_nettype none

interface ee_link_if;
  logic chipSelect;
  logic serialClock;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  wire serialLine;

  // a released line reads as its pull-up level
  assign serialLine = serialOutEn ? serialOut : 1'b1;

  modport device(input chipSelect, input serialClock, input serialIn,
    output serialOut, output serialOutEn);
  modport host(output chipSelect, output serialClock, output serialIn, input serialLine);
endinterface : ee_link_if

`default_nettype wire

// file: core/ee_device.sv
// device end: sixteen 16-bit words behind a three-wire serial port
// assumes the host gives one serial clock edge with chip select low after reset
`timescale 1ns/1ps
`default_nettype none
`include "ee_regs.svh"

module ee_device import ee_pkg::*; (
  // link
  ee_link_if.device link,
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // status
  output logic programEnabled,
  output logic highVoltage
);

  // ==========================================================
  // link domain: shifting and decoding
  // ==========================================================
  ee_dev_state_t devState_reg;
  logic [`EE_CNT_W-1:0] bitCnt_reg;
  logic [7:0] cmdShift_reg;
  ee_word_t dataShift_reg;
  ee_word_t readShift_reg;
  logic outBit_reg;
  logic outEn_reg;
  logic [7:0] cmdHold_reg;
  ee_word_t dataHold_reg;
  logic cmdPending_reg;

  logic [15:0] memArray [`EE_WORDS];

  wire logic [7:0] cmdFull;
  wire logic [1:0] cmdKind;
  wire ee_op_t cmdOp;
  wire ee_addr_t cmdAddr;
  wire ee_word_t dataFull;
  wire ee_word_t readWord;
  wire logic lastCmdBit;
  wire logic lastDataBit;
  wire logic readDone;
  wire logic isRead;
  wire logic hasData;

  assign cmdFull = {cmdShift_reg[6:0], link.serialIn};
  assign cmdOp = cmdFull[7:4];
  assign cmdKind = cmdFull[7:6];
  assign cmdAddr = cmdFull[3:0];
  assign dataFull = {dataShift_reg[`EE_WIDTH-2:0], link.serialIn};
  assign lastCmdBit = bitCnt_reg == `EE_CNT_W'(`EE_OP_W + `EE_ADDR_W - 1);
  assign lastDataBit = bitCnt_reg == `EE_CNT_W'(`EE_WIDTH - 1);
  assign readDone = bitCnt_reg == `EE_CNT_W'(`EE_WIDTH);
  assign isRead = cmdKind == `EE_KIND_READ;
  assign hasData = (cmdKind == `EE_KIND_WRITE) || (cmdOp == `EE_OP_WRITE_ALL);
  // the array only changes while chip select is low, so it is steady here
  assign readWord = memArray[cmdAddr];

  // chip select low clears the frame at the next serial clock edge;
  // leading zeros before the start bit are skipped
  always_ff @(posedge link.serialClock) begin
    if (!link.chipSelect) begin
      devState_reg <= EE_DEV_IDLE;
      bitCnt_reg <= '0;
      outBit_reg <= 1'b0;
      outEn_reg <= 1'b0;
      cmdPending_reg <= 1'b0;
    end else begin
      case (devState_reg)
        EE_DEV_IDLE: begin
          if (link.serialIn == `EE_START_BIT) begin
            devState_reg <= EE_DEV_CMD;
            bitCnt_reg <= '0;
          end
        end
        EE_DEV_CMD: begin
          cmdShift_reg <= cmdFull;
          bitCnt_reg <= bitCnt_reg + `EE_CNT_W'(1);
          if (lastCmdBit) begin
            bitCnt_reg <= '0;
            if (isRead) begin
              devState_reg <= EE_DEV_READ;
              readShift_reg <= readWord;
              outBit_reg <= 1'b0;
              outEn_reg <= 1'b1;
            end else if (hasData) begin
              devState_reg <= EE_DEV_DATA;
            end else begin
              cmdHold_reg <= cmdFull;
              cmdPending_reg <= 1'b1;
              devState_reg <= EE_DEV_DONE;
            end
          end
        end
        EE_DEV_DATA: begin
          dataShift_reg <= dataFull;
          bitCnt_reg <= bitCnt_reg + `EE_CNT_W'(1);
          if (lastDataBit) begin
            cmdHold_reg <= cmdShift_reg;
            dataHold_reg <= dataFull;
            cmdPending_reg <= 1'b1;
            devState_reg <= EE_DEV_DONE;
          end
        end
        EE_DEV_READ: begin
          if (readDone) begin
            outEn_reg <= 1'b0;
            devState_reg <= EE_DEV_DONE;
          end else begin
            outBit_reg <= readShift_reg[`EE_WIDTH-1];
            readShift_reg <= {readShift_reg[`EE_WIDTH-2:0], 1'b0};
            bitCnt_reg <= bitCnt_reg + `EE_CNT_W'(1);
          end
        end
        default: begin
          devState_reg <= EE_DEV_DONE;
        end
      endcase
    end
  end

  assign link.serialOut = outBit_reg;
  assign link.serialOutEn = outEn_reg;

  // ==========================================================
  // system domain: enable latch and programming cycle
  // ==========================================================
  // the host may stop the serial clock during the pulse, so the cycle is
  // timed here from chip select alone
  logic csSync1_reg;
  logic csSync2_reg;
  logic csPrev_reg;
  logic pendSync1_reg;
  logic pendSync2_reg;
  logic pendPrev_reg;
  logic progEn_reg;
  logic hv_reg;

  wire logic [1:0] holdKind;
  wire ee_op_t holdOp;
  wire ee_addr_t holdAddr;
  wire logic csFall;
  wire logic pendRise;
  wire logic progOp;
  wire logic eraseOp;
  wire logic allWords;
  wire logic progStart;

  // cmdHold/dataHold stay still while the pending level is high
  assign holdOp = cmdHold_reg[7:4];
  assign holdKind = cmdHold_reg[7:6];
  assign holdAddr = cmdHold_reg[3:0];
  assign csFall = csPrev_reg && !csSync2_reg;
  assign pendRise = pendSync2_reg && !pendPrev_reg;
  assign progOp = (holdKind != `EE_KIND_SPECIAL) || (holdOp == `EE_OP_ERASE_ALL)
    || (holdOp == `EE_OP_WRITE_ALL);
  assign eraseOp = (holdKind == `EE_KIND_ERASE) || (holdOp == `EE_OP_ERASE_ALL);
  assign allWords = (holdOp == `EE_OP_ERASE_ALL) || (holdOp == `EE_OP_WRITE_ALL);
  assign progStart = csFall && pendSync2_reg && progOp && progEn_reg;

  always_ff @(posedge clk_sys) begin
    csSync1_reg <= link.chipSelect;
    csSync2_reg <= csSync1_reg;
    pendSync1_reg <= cmdPending_reg;
    pendSync2_reg <= pendSync1_reg;
    if (rst) begin
      csPrev_reg <= 1'b0;
      pendPrev_reg <= 1'b0;
      progEn_reg <= 1'b0;
      hv_reg <= 1'b0;
    end else begin
      csPrev_reg <= csSync2_reg;
      pendPrev_reg <= pendSync2_reg;
      if (pendRise && holdOp == `EE_OP_ENABLE) begin
        progEn_reg <= 1'b1;
      end else if (pendRise && holdOp == `EE_OP_DISABLE) begin
        progEn_reg <= 1'b0;
      end
      if (csSync2_reg) begin
        hv_reg <= 1'b0;
      end else if (progStart) begin
        hv_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // storage array
  // ==========================================================
  // a write can only clear bits, as in the cell itself; reset stands in for
  // an erased part since nothing here survives power
  genvar w;
  generate
    for (w = 0; w < `EE_WORDS; w++) begin : g_word
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          memArray[w] <= `EE_ERASED;
        end else if (progStart && (allWords || holdAddr == `EE_ADDR_W'(w))) begin
          memArray[w] <= eraseOp ? `EE_ERASED : (memArray[w] & dataHold_reg);
        end
      end
    end
  endgenerate

  assign programEnabled = progEn_reg;
  assign highVoltage = hv_reg;

endmodule : ee_device

`default_nettype wire

// file: core/ee_host.sv
// host end: issues one instruction per request over the serial link
// assumes the caller erases a word before asking for a single-word write
`timescale 1ns/1ps
`default_nettype none
`include "ee_regs.svh"

module ee_host import ee_pkg::*; #(
  parameter int PROG_CYCLES = `EE_PROG_CYC,
  parameter int HALF_CYCLES = `EE_LINK_HALF,
  parameter int CS_LOW = `EE_CS_LOW_CYC
) (
  // link
  ee_link_if.host link,
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // request
  input wire logic reqValid,
  input wire ee_op_t reqOp,
  input wire ee_addr_t reqAddr,
  input wire ee_word_t reqData,
  output logic reqReady,
  // answer
  output logic doneValid,
  output ee_word_t readData
);

  // ==========================================================
  // state
  // ==========================================================
  ee_host_state_t state_reg;
  logic [15:0] halfCnt_reg;
  logic [23:0] waitCnt_reg;
  logic [`EE_CNT_W-1:0] slotCnt_reg;
  logic [`EE_CNT_W-1:0] slotLast_reg;
  logic [24:0] tx_reg;
  ee_word_t rx_reg;
  logic linkClk_reg;
  logic cs_reg;
  logic si_reg;
  logic isProg_reg;
  logic isRead_reg;
  logic tail_reg;
  logic live_reg;
  logic ready_reg;
  logic done_reg;
  ee_word_t rdData_reg;
  logic lineSync1_reg;
  logic lineSync2_reg;

  wire logic slotActive;
  wire logic halfDone;
  wire logic slotEnd;
  wire logic reqRead;
  wire logic reqLong;
  wire logic reqProg;
  wire logic waitDone;

  assign slotActive = (state_reg == EE_HOST_FRAME) || (state_reg == EE_HOST_FLUSH)
    || (state_reg == EE_HOST_ENDHI);
  assign halfDone = halfCnt_reg == 16'(HALF_CYCLES - 1);
  assign slotEnd = slotActive && halfDone && linkClk_reg;
  assign reqRead = reqOp[3:2] == `EE_KIND_READ;
  assign reqLong = reqRead || reqOp[3:2] == `EE_KIND_WRITE || reqOp == `EE_OP_WRITE_ALL;
  assign reqProg = reqOp[3:2] != `EE_KIND_SPECIAL || reqOp == `EE_OP_ERASE_ALL
    || reqOp == `EE_OP_WRITE_ALL;
  assign waitDone = waitCnt_reg == 24'h000000;

  // ==========================================================
  // serial clock divider and frame sequencer
  // ==========================================================
  always_ff @(posedge clk_sys) begin
    lineSync1_reg <= link.serialLine;
    lineSync2_reg <= lineSync1_reg;
    if (rst) begin
      state_reg <= EE_HOST_FLUSH;
      halfCnt_reg <= '0;
      waitCnt_reg <= '0;
      slotCnt_reg <= '0;
      slotLast_reg <= '0;
      tx_reg <= '0;
      rx_reg <= '0;
      linkClk_reg <= 1'b0;
      cs_reg <= 1'b0;
      si_reg <= 1'b0;
      isProg_reg <= 1'b0;
      isRead_reg <= 1'b0;
      tail_reg <= 1'b1;
      live_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      rdData_reg <= '0;
    end else begin
      done_reg <= 1'b0;
      if (slotActive) begin
        halfCnt_reg <= halfDone ? 16'h0000 : halfCnt_reg + 16'h0001;
        if (halfDone) begin
          linkClk_reg <= !linkClk_reg;
        end
      end
      case (state_reg)
        EE_HOST_IDLE: begin
          if (reqValid && ready_reg) begin
            ready_reg <= 1'b0;
            live_reg <= 1'b1;
            isRead_reg <= reqRead;
            isProg_reg <= reqProg;
            tail_reg <= 1'b0;
            // lead zero slot with select high comes before the start bit
            tx_reg <= {`EE_START_BIT, reqOp, reqAddr, reqData};
            slotLast_reg <= reqLong ? `EE_SLOT_DATA_LAST : `EE_SLOT_CMD_LAST;
            slotCnt_reg <= '0;
            si_reg <= 1'b0;
            cs_reg <= 1'b1;
            state_reg <= EE_HOST_FRAME;
          end
        end
        EE_HOST_FRAME: begin
          if (slotEnd) begin
            slotCnt_reg <= slotCnt_reg + `EE_CNT_W'(1);
            si_reg <= tx_reg[24];
            tx_reg <= {tx_reg[23:0], 1'b0};
            if (isRead_reg && slotCnt_reg >= `EE_SLOT_CMD_LAST) begin
              rx_reg <= {rx_reg[`EE_WIDTH-2:0], lineSync2_reg};
            end
            if (slotCnt_reg == slotLast_reg) begin
              cs_reg <= 1'b0;
              si_reg <= 1'b0;
              state_reg <= EE_HOST_FLUSH;
            end
          end
        end
        EE_HOST_FLUSH: begin
          // one clock with select low resets the far end's frame logic
          if (slotEnd) begin
            waitCnt_reg <= (isProg_reg && !tail_reg) ? 24'(PROG_CYCLES - 1)
              : 24'(CS_LOW - 1);
            state_reg <= EE_HOST_WAIT;
          end
        end
        EE_HOST_WAIT: begin
          waitCnt_reg <= waitCnt_reg - 24'h000001;
          if (waitDone) begin
            if (isProg_reg && !tail_reg) begin
              tail_reg <= 1'b1;
              cs_reg <= 1'b1;
              state_reg <= EE_HOST_ENDHI;
            end else begin
              done_reg <= live_reg;
              live_reg <= 1'b0;
              rdData_reg <= isRead_reg ? rx_reg : rdData_reg;
              ready_reg <= 1'b1;
              state_reg <= EE_HOST_IDLE;
            end
          end
        end
        default: begin
          if (slotEnd) begin
            cs_reg <= 1'b0;
            state_reg <= EE_HOST_FLUSH;
          end
        end
      endcase
    end
  end

  assign link.chipSelect = cs_reg;
  assign link.serialClock = linkClk_reg;
  assign link.serialIn = si_reg;
  assign reqReady = ready_reg;
  assign doneValid = done_reg;
  assign readData = rdData_reg;

endmodule : ee_host

`default_nettype wire

// file: verification/ee_link_sva.sv
// assertions on the serial link that joins the host end to the device end
// assumes a host built with HALF_CYCLES 4 and CS_LOW 5, so one slot is eight clk_sys cycles
`timescale 1ns/1ps
`default_nettype none

module ee_link_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link
  input wire logic chipSelect,
  input wire logic serialClock,
  input wire logic serialIn,
  input wire logic serialOut,
  input wire logic serialOutEn
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // ========
  // helper: link clock rises counted while the data line is driven
  logic clkPrev_reg;
  logic [4:0] riseCnt_reg;
  logic [4:0] riseCnt_next;
  wire logic clkRise = serialClock & ~clkPrev_reg;
  assign riseCnt_next = serialOutEn ? riseCnt_reg + {4'h0, clkRise} : 5'h00;
  always_ff @(posedge clk_sys) begin
    clkPrev_reg <= rst ? 1'b0 : serialClock;
    riseCnt_reg <= rst ? 5'h00 : riseCnt_next;
  end

  // ========
  // properties
  property p_outEdge;
    serialOutEn && $changed(serialOut) |-> $rose(serialClock);
  endproperty
  a_outEdge: assert property (p_outEdge) else $error("data out moved off a clock rise");
  property p_outStart;
    $rose(serialOutEn) |-> $rose(serialClock) && chipSelect && !serialOut;
  endproperty
  a_outStart: assert property (p_outStart) else $error("read output began wrongly");
  property p_outLen;
    serialOutEn |-> riseCnt_reg <= 5'h11;
  endproperty
  a_outLen: assert property (p_outLen) else $error("read output driven too long");
  // dummy zero plus sixteen data bits, then released on the next rise
  // the enable is unknown until the first link clock with select low, so the
  // release is seen through $past rather than $fell
  property p_outFall;
    !serialOutEn && $past(serialOutEn) |-> riseCnt_reg == 5'h11 && $rose(serialClock);
  endproperty
  a_outFall: assert property (p_outFall) else $error("read output released early");
  property p_clkHigh;
    $rose(serialClock) |=> $stable(serialClock)[*3];
  endproperty
  a_clkHigh: assert property (p_clkHigh) else $error("link clock high phase too short");
  property p_lead;
    $rose(chipSelect) |-> ##[1:6] ($rose(serialClock) && !serialIn && chipSelect);
  endproperty
  a_lead: assert property (p_lead) else $error("no lead clock before start bit");
  // a select-high slot that only closes a programming cycle carries no start bit
  property p_startBit;
    $rose(chipSelect) ##1 chipSelect[*8] |-> ##[1:6] ($rose(serialClock) && serialIn);
  endproperty
  a_startBit: assert property (p_startBit) else $error("start bit missing");
  property p_csLow;
    $fell(chipSelect) |-> !chipSelect[*5];
  endproperty
  a_csLow: assert property (p_csLow) else $error("select low gap too short");
  property p_siEdge;
    chipSelect && $past(chipSelect) && $changed(serialIn) |-> !serialClock;
  endproperty
  a_siEdge: assert property (p_siEdge) else $error("data in moved while clock high");
endmodule : ee_link_sva

`default_nettype wire

// file: verification/serial_eeprom_16x16_port_tb.sv
// bench: host and device ends on one link, plus a second device driven by hand
// assumes the core files and ee_regs.svh are compiled first
`timescale 1ns/1ps
`default_nettype none

module serial_eeprom_16x16_port_tb import ee_pkg::*;;
  // ========
  // signals and instances
  logic clk_sys, rst, reqValid, reqReady, doneValid, programEnabled, highVoltage;
  logic programEnabled2, highVoltage2, hvSeen, oeSeen;
  ee_op_t reqOp;
  ee_addr_t reqAddr;
  ee_word_t reqData, readData;
  int n_errors, tests_run;
  ee_link_if link();
  ee_link_if link2();
  // short program time and slots keep the run small
  ee_host #(.PROG_CYCLES(50), .HALF_CYCLES(4), .CS_LOW(5)) ee_host_inst (.link(link),
    .clk_sys(clk_sys), .rst(rst), .reqValid(reqValid), .reqOp(reqOp), .reqAddr(reqAddr),
    .reqData(reqData), .reqReady(reqReady), .doneValid(doneValid), .readData(readData));
  ee_device ee_device_inst (.link(link), .clk_sys(clk_sys), .rst(rst),
    .programEnabled(programEnabled), .highVoltage(highVoltage));
  // the bench plays a host here that cuts the program pulse short
  ee_device ee_device_fault_inst (.link(link2), .clk_sys(clk_sys), .rst(rst),
    .programEnabled(programEnabled2), .highVoltage(highVoltage2));
  ee_link_sva ee_link_sva_inst (.clk_sys(clk_sys), .rst(rst), .chipSelect(link.chipSelect),
    .serialClock(link.serialClock), .serialIn(link.serialIn), .serialOut(link.serialOut),
    .serialOutEn(link.serialOutEn));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (highVoltage === 1'b1) begin
      hvSeen = 1'b1;
    end
    if (link.serialOutEn === 1'b1) begin
      oeSeen = 1'b1;
    end
  end

  // ========
  // shared tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  task automatic doOp(input ee_op_t op, input ee_addr_t addr, input ee_word_t data);
    int i;
    i = 0;
    while (reqReady !== 1'b1 && i < 1000) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (i >= 1000) begin
      n_errors++;
      $display("Error at %0t: host never ready", $time);
      end_sim();
    end
    reqValid = 1'b1;
    reqOp = op;
    reqAddr = addr;
    reqData = data;
    @(posedge clk_sys);
    #1;
    reqValid = 1'b0;
    i = 0;
    while (doneValid !== 1'b1 && i < 1000) begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    if (i >= 1000) begin
      n_errors++;
      $display("Error at %0t: request never finished", $time);
      end_sim();
    end
  endtask : doOp

  // ten link bits, lead zero first; select drops well after the last rise
  task automatic frame2(input logic [9:0] bits);
    int k;
    link2.chipSelect = 1'b1;
    for (k = 9; k >= 0; k--) begin
      link2.serialIn = bits[k];
      #7.5 link2.serialClock = 1'b1;
      #7.5 link2.serialClock = 1'b0;
    end
    #30 link2.chipSelect = 1'b0;
  endtask : frame2

  task automatic gap2;
    #7.5 link2.serialClock = 1'b1;
    #7.5 link2.serialClock = 1'b0;
    #100;
  endtask : gap2

  // ========
  // scenarios
  task automatic scReadDisabled;
    check({14'h0, programEnabled, highVoltage}, 16'h0000);
    oeSeen = 1'b0;
    doOp(4'h8, 4'h3, 16'h0000);
    check(readData, 16'hffff);
    check({15'h0, oeSeen}, 16'h0001);
    doOp(4'hb, 4'hc, 16'h0000);
    check(readData, 16'hffff);
  endtask : scReadDisabled

  task automatic scRefused;
    hvSeen = 1'b0;
    oeSeen = 1'b0;
    doOp(4'h4, 4'h3, 16'h1234);
    doOp(4'h2, 4'h0, 16'h0000);
    check({14'h0, hvSeen, oeSeen}, 16'h0000);
    doOp(4'h8, 4'h3, 16'h0000);
    check(readData, 16'hffff);
  endtask : scRefused

  task automatic scEnable;
    doOp(4'h3, 4'h9, 16'h0000);
    check({15'h0, programEnabled}, 16'h0001);
  endtask : scEnable

  task automatic scWrite;
    hvSeen = 1'b0;
    oeSeen = 1'b0;
    doOp(4'h5, 4'h5, 16'ha55a);
    check({14'h0, hvSeen, oeSeen}, 16'h0002);
    doOp(4'ha, 4'h5, 16'h0000);
    check(readData, 16'ha55a);
    doOp(4'h8, 4'h4, 16'h0000);
    check(readData, 16'hffff);
  endtask : scWrite

  task automatic scErase;
    doOp(4'he, 4'h5, 16'h0000);
    doOp(4'h9, 4'h5, 16'h0000);
    check(readData, 16'hffff);
  endtask : scErase

  task automatic scWriteAll;
    int k;
    doOp(4'h1, 4'h7, 16'h0ff0);
    for (k = 0; k < 2; k++) begin
      doOp(4'h8, (k == 0) ? 4'h0 : 4'hf, 16'h0000);
      check(readData, 16'h0ff0);
    end
  endtask : scWriteAll

  task automatic scEraseAll;
    doOp(4'h2, 4'h6, 16'h0000);
    doOp(4'h8, 4'h0, 16'h0000);
    check(readData, 16'hffff);
    doOp(4'h8, 4'h9, 16'h0000);
    check(readData, 16'hffff);
  endtask : scEraseAll

  task automatic scDisable;
    doOp(4'h0, 4'hf, 16'h0000);
    check({15'h0, programEnabled}, 16'h0000);
    hvSeen = 1'b0;
    doOp(4'h1, 4'h0, 16'h0000);
    check({15'h0, hvSeen}, 16'h0000);
    doOp(4'h8, 4'h2, 16'h0000);
    check(readData, 16'hffff);
  endtask : scDisable

  task automatic scCutProgram;
    gap2();
    frame2(10'h130);
    gap2();
    check({15'h0, programEnabled2}, 16'h0001);
    frame2(10'h1c3);
    #50;
    check({15'h0, highVoltage2}, 16'h0001);
    link2.chipSelect = 1'b1;
    #50;
    check({15'h0, highVoltage2}, 16'h0000);
    link2.chipSelect = 1'b0;
    gap2();
  endtask : scCutProgram

  // ========
  // main sequence
  initial begin
    rst = 1'b1;
    reqValid = 1'b0;
    reqOp = 4'h0;
    reqAddr = 4'h0;
    reqData = 16'h0000;
    n_errors = 0;
    tests_run = 0;
    hvSeen = 1'b0;
    oeSeen = 1'b0;
    link2.chipSelect = 1'b0;
    link2.serialClock = 1'b0;
    link2.serialIn = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    scReadDisabled();
    scRefused();
    scEnable();
    scWrite();
    scErase();
    scWriteAll();
    scEraseAll();
    scDisable();
    scCutProgram();
    end_sim();
  end
endmodule : serial_eeprom_16x16_port_tb

`default_nettype wire
